// ---- logic/sofa_core.sv ----
/*
  sensor core: offset, alert compare, unique and short addressing.
  assumes a register master on i_clk, conversion results on i_clk,
  external configuration storage, and asynchronous pins.
*/
// The register addresses and the strobed register port are this design's own decisions.
`include "sofa_params.svh"
`timescale 1ns/1ns
`default_nettype none
module sofa_core
  import sofa_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [47:0] SERIAL = 48'h0123_4567_89AB, // arbitrary value
  parameter int STRAP_IDLE_CYCLES = `SOFA_STRAP_IDLE_NS / `SOFA_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_conv_done,
  input wire logic [15:0] i_raw_temp,
  input wire logic i_shutdown,
  input wire sofa_nv_type i_nv_data,
  output sofa_nv_type o_nv_data,
  output logic o_nv_wr,
  input wire logic i_supply_powered,
  input wire logic i_bus_data_line,
  input wire logic [9:0] i_strap_level,
  input wire logic [3:0] i_general_purpose_pins,
  output logic [3:0] o_general_purpose_pins,
  output logic [3:0] o_general_purpose_pins_oe_n,
  output logic o_threshold_flag_pin,
  output logic o_threshold_flag_pin_oe_n,
  input wire logic i_uid_rewind,
  input wire logic i_uid_next,
  input wire logic i_uid_cmp_bit,
  output logic o_uid_bit,
  output logic o_uid_match
);
  // ******************************
  // elaboration checks
  // ******************************
  // refused while elaborating: a zero count would wrap the quiet limit to all ones and stall the wait
  if (STRAP_IDLE_CYCLES < 1) begin
    $error("strap idle count must be at least one cycle");
  end

  // ******************************
  // unique address
  // ******************************
  // reflected crc over the 56 low bits, lsb first from a zero seed
  function automatic logic [7:0] crc56(input logic [55:0] data);
    logic [7:0] crc;
    crc = `SOFA_CRC_SEED;
    for (int i = 0; i < 56; i++) begin
      if (crc[0] ^ data[i]) begin
        crc = (crc >> 1) ^ `SOFA_CRC_POLY_REFL;
      end else begin
        crc = crc >> 1;
      end
    end
    return crc;
  endfunction

  localparam logic [63:0] UID = {crc56({SERIAL, FAMILY_CODE}), SERIAL, FAMILY_CODE};
  localparam logic [149:0] BOUNDS = `SOFA_STRAP_BOUNDS;

  // ******************************
  // pin synchronisers
  // ******************************
  logic [5:0] sync1_q; // first stage, read only by second stage
  logic [5:0] sync2_q; // {bus line, supply, pins}
  // two flops on every asynchronous pin
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {i_bus_data_line, i_supply_powered, i_general_purpose_pins};
      sync2_q <= sync1_q;
    end
  end
  logic [3:0] pins_s;
  logic supply_s;
  logic bus_s;
  assign pins_s = sync2_q[3:0];
  assign supply_s = sync2_q[4];
  assign bus_s = sync2_q[5];

  // ******************************
  // registers
  // ******************************
  logic [15:0] result_q; // reads zero before first conversion
  logic [1:0] flags_q; // {high, low}
  logic alert_mode_q; // 0 latched until read, 1 follows compare
  logic [1:0] sel_q; // short address source select
  logic [7:0] short_q;
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic [15:0] offset_q;
  logic [4:0] io_cfg_q; // {alert enable, output dir[3:0]}
  logic [3:0] io_out_q; // output levels of general purpose pins
  logic loaded_q; // storage values taken after reset release
  logic wr_cfg2;
  logic wr_short;
  logic rd_status;
  assign wr_cfg2 = i_wr && (i_addr == `SOFA_REG_CFG2);
  assign wr_short = i_wr && (i_addr == `SOFA_REG_SHORT);
  assign rd_status = i_rd && (i_addr == `SOFA_REG_STATUS);

  logic signed [15:0] adj_temp;
  assign adj_temp = $signed(i_raw_temp) + $signed(offset_q);

  // conversion result register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result_q <= 16'h0000;
    end else if (i_conv_done) begin
      result_q <= adj_temp;
    end
  end

  logic below;
  logic above;
  assign below = adj_temp < $signed(lo_q);
  assign above = adj_temp > $signed(hi_q);

  // clear by status read or by compare
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_q <= 2'h0;
    end else if (i_conv_done && alert_mode_q) begin
      // comparator mode: flags track the newest result
      flags_q <= {above, below};
    end else if (i_conv_done) begin
      // latched mode: a new event wins over a read that clears
      flags_q <= (rd_status ? 2'h0 : flags_q) | {above, below};
    end else if (rd_status && !alert_mode_q) begin
      flags_q <= 2'h0;
    end
  end

  // configuration and limit registers, with storage load after reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alert_mode_q <= 1'b0;
      lo_q <= 16'h8000;
      hi_q <= 16'h7FFF;
      io_cfg_q <= 5'h00;
      io_out_q <= 4'hF;
      offset_q <= 16'h0000;
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      if (!loaded_q) begin
        offset_q <= i_nv_data.offset;
      end else if (i_wr && i_addr == `SOFA_REG_OFFSET) begin
        offset_q <= i_wdata;
      end
      if (i_wr && i_addr == `SOFA_REG_CFG1) begin
        alert_mode_q <= i_wdata[`SOFA_CFG1_ALERT_MODE];
      end
      if (i_wr && i_addr == `SOFA_REG_ALERT_LO) begin
        lo_q <= i_wdata;
      end
      if (i_wr && i_addr == `SOFA_REG_ALERT_HI) begin
        hi_q <= i_wdata;
      end
      if (i_wr && i_addr == `SOFA_REG_IO_CFG) begin
        io_cfg_q <= i_wdata[4:0];
        io_out_q <= i_wdata[11:8];
      end
    end
  end

  // ******************************
  // short address sequencer
  // ******************************
  sofa_seq_type seq_q;
  logic [31:0] quiet_q; // idle cycles seen on the bus in shutdown
  logic [3:0] strap_q; // decoded strap code
  logic [1:0] seq_sel_q; // mode that started the sequence
  logic [3:0] strap_code;

  // count bounds below level, open reads 1111b
  always_comb begin
    strap_code = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if (i_strap_level > BOUNDS[i*10 +: 10]) begin
        strap_code = 4'(i + 1);
      end
    end
  end

  // pins in output mode latch as zero
  logic [3:0] pin_bits;
  assign pin_bits = pins_s & ~io_cfg_q[3:0];

  // sequencer: host-started strap modes wait for shutdown and a quiet bus
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_q <= SOFA_IDLE;
      quiet_q <= 32'h0000_0000;
      strap_q <= 4'h0;
      seq_sel_q <= `SOFA_SEL_HOST;
    end else begin
      case (seq_q)
        SOFA_IDLE: begin
          quiet_q <= 32'h0000_0000;
          if (!loaded_q && i_nv_data.combined) begin
            seq_sel_q <= `SOFA_SEL_BOTH;
            seq_q <= SOFA_SAMPLE_STRAP;
          // host holds 00b, then writes mode
          end else if (wr_cfg2 && sel_q == `SOFA_SEL_HOST
                       && i_wdata[1:0] != `SOFA_SEL_HOST) begin
            seq_sel_q <= i_wdata[1:0];
            if (i_wdata[1:0] == `SOFA_SEL_PINS) begin
              seq_q <= SOFA_SAMPLE_PINS;
            end else begin
              seq_q <= SOFA_WAIT_QUIET;
            end
          end
        end
        SOFA_WAIT_QUIET: begin
          // host keeps bus idle in shutdown
          if (!(i_shutdown && bus_s)) begin
            quiet_q <= 32'h0000_0000;
          end else if (quiet_q >= 32'(STRAP_IDLE_CYCLES - 1)) begin
            seq_q <= SOFA_SAMPLE_STRAP;
          end else begin
            quiet_q <= quiet_q + 32'h0000_0001;
          end
          // returning to 00b abandons the decode
          if (wr_cfg2 && i_wdata[1:0] == `SOFA_SEL_HOST) begin
            seq_q <= SOFA_IDLE;
          end
        end
        SOFA_SAMPLE_STRAP: begin
          strap_q <= strap_code;
          if (seq_sel_q == `SOFA_SEL_BOTH) begin
            seq_q <= SOFA_SAMPLE_PINS;
          end else begin
            seq_q <= SOFA_UPDATE;
          end
        end
        SOFA_SAMPLE_PINS: begin
          seq_q <= SOFA_IDLE;
        end
        SOFA_UPDATE: begin
          seq_q <= SOFA_IDLE;
        end
        default: begin
          seq_q <= SOFA_IDLE;
        end
      endcase
    end
  end

  // source select field, stored in configuration storage only as the combined flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= `SOFA_SEL_HOST;
    end else if (!loaded_q && i_nv_data.combined) begin
      sel_q <= `SOFA_SEL_BOTH;
    end else if (wr_cfg2) begin
      sel_q <= i_wdata[1:0];
    end
  end

  // short address register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      short_q <= 8'h00;
    end else if (!loaded_q) begin
      // stored short address at power up
      short_q <= i_nv_data.short_addr;
    end else if (seq_q == SOFA_SAMPLE_PINS && seq_sel_q == `SOFA_SEL_PINS) begin
      short_q <= {short_q[7:4], pin_bits};
    end else if (seq_q == SOFA_SAMPLE_PINS) begin
      // strap low, pins one and zero above
      short_q <= {short_q[7:6], pin_bits[1:0], strap_q};
    end else if (seq_q == SOFA_UPDATE) begin
      short_q <= {short_q[7:4], strap_q};
    end else if (wr_short && sel_q == `SOFA_SEL_HOST) begin
      short_q <= i_wdata[7:0];
    end
  end

  // ******************************
  // storage commit
  // ******************************
  // commit offset, short address and combined flag, each on its own select bit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_nv_wr <= 1'b0;
      o_nv_data <= '0;
    end else begin
      o_nv_wr <= i_wr && (i_addr == `SOFA_REG_COMMIT) && (i_wdata[2:0] != 3'h0);
      if (i_wr && i_addr == `SOFA_REG_COMMIT) begin
        o_nv_data <= i_nv_data;
        if (i_wdata[`SOFA_COMMIT_OFFSET]) begin
          o_nv_data.offset <= offset_q;
        end
        if (i_wdata[`SOFA_COMMIT_SHORT]) begin
          o_nv_data.short_addr <= short_q;
        end
        if (i_wdata[`SOFA_COMMIT_MODE]) begin
          o_nv_data.combined <= (sel_q == `SOFA_SEL_BOTH);
        end
      end
    end
  end

  // ******************************
  // pins
  // ******************************
  // open drain: enable low only while pulling the pin low
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_general_purpose_pins <= 4'h0;
      o_general_purpose_pins_oe_n <= 4'hF;
      o_threshold_flag_pin <= 1'b0;
      o_threshold_flag_pin_oe_n <= 1'b1;
    end else begin
      o_general_purpose_pins <= 4'h0;
      o_general_purpose_pins_oe_n <= ~(io_cfg_q[3:0] & ~io_out_q);
      o_threshold_flag_pin <= 1'b0;
      // alert pin low while a flag stands
      if (io_cfg_q[`SOFA_IO_ALERT_EN] && supply_s) begin
        o_threshold_flag_pin_oe_n <= ~(|flags_q);
        o_general_purpose_pins_oe_n[2] <= 1'b1;
      end else begin
        o_threshold_flag_pin_oe_n <= 1'b1;
      end
    end
  end

  // ******************************
  // unique address serial port
  // ******************************
  logic [5:0] uid_idx_q;
  // bit index climbs from bit 0
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      uid_idx_q <= 6'h00;
      o_uid_match <= 1'b1;
    end else if (i_uid_rewind) begin
      uid_idx_q <= 6'h00;
      o_uid_match <= 1'b1;
    end else if (i_uid_next) begin
      uid_idx_q <= uid_idx_q + 6'h01;
      o_uid_match <= o_uid_match && (i_uid_cmp_bit == UID[uid_idx_q]);
    end
  end
  assign o_uid_bit = UID[uid_idx_q];

  // ******************************
  // register read
  // ******************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0000;
    end else if (!i_rd) begin
      o_rdata <= 16'h0000;
    end else if (i_addr == `SOFA_REG_RESULT) begin
      o_rdata <= result_q;
    end else if (i_addr == `SOFA_REG_STATUS) begin
      o_rdata <= {14'h0000, flags_q};
    end else if (i_addr == `SOFA_REG_CFG1) begin
      o_rdata <= {15'h0000, alert_mode_q};
    end else if (i_addr == `SOFA_REG_CFG2) begin
      o_rdata <= {14'h0000, sel_q};
    end else if (i_addr == `SOFA_REG_SHORT) begin
      o_rdata <= {8'h00, short_q};
    end else if (i_addr == `SOFA_REG_ALERT_LO) begin
      o_rdata <= lo_q;
    end else if (i_addr == `SOFA_REG_ALERT_HI) begin
      o_rdata <= hi_q;
    end else if (i_addr == `SOFA_REG_OFFSET) begin
      o_rdata <= offset_q;
    end else if (i_addr == `SOFA_REG_IO_CFG) begin
      o_rdata <= {4'h0, io_out_q, 3'h0, io_cfg_q};
    end else if (i_addr == `SOFA_REG_IO_READ) begin
      o_rdata <= {12'h000, pins_s};
    end else if (i_addr >= `SOFA_REG_UID0 && i_addr <= `SOFA_REG_UID3) begin
      // low word of the unique address first
      o_rdata <= UID[16*(i_addr - `SOFA_REG_UID0) +: 16];
    end else begin
      o_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- logic/sofa_params.svh ----
/*
  constants for the sensor offset, alert and addressing core.
  assumes inclusion by bare name from logic/ and a 50 MHz core clock.
*/
`ifndef SOFA_PARAMS_SVH
`define SOFA_PARAMS_SVH
// ******************************
// register indices
// ******************************
`define SOFA_REG_RESULT 8'h00
`define SOFA_REG_STATUS 8'h01
`define SOFA_REG_CFG1 8'h02
`define SOFA_REG_CFG2 8'h03
`define SOFA_REG_SHORT 8'h04
`define SOFA_REG_ALERT_LO 8'h05
`define SOFA_REG_ALERT_HI 8'h06
`define SOFA_REG_OFFSET 8'h07
`define SOFA_REG_IO_CFG 8'h08
`define SOFA_REG_IO_READ 8'h09
`define SOFA_REG_UID0 8'h0A
`define SOFA_REG_UID3 8'h0D
`define SOFA_REG_COMMIT 8'h0E
// ******************************
// field positions and values
// ******************************
`define SOFA_ST_LOW 0
`define SOFA_ST_HIGH 1
`define SOFA_CFG1_ALERT_MODE 0
`define SOFA_IO_ALERT_EN 4
`define SOFA_COMMIT_OFFSET 0
`define SOFA_COMMIT_SHORT 1
`define SOFA_COMMIT_MODE 2
`define SOFA_SEL_HOST 2'h0
`define SOFA_SEL_PINS 2'h1
`define SOFA_SEL_STRAP 2'h2
`define SOFA_SEL_BOTH 2'h3
`define SOFA_CRC_POLY_REFL 8'h8C
`define SOFA_CRC_SEED 8'h00
`define SOFA_STRAP_OPEN 4'hF
// upper bounds of strap codes 0..14, strap level in tenths of a kilohm
`define SOFA_STRAP_BOUNDS {10'h200, 10'h1C1, 10'h18E, 10'h161, 10'h13D, \
  10'h11C, 10'h0FC, 10'h0DD, 10'h0C0, 10'h0A6, 10'h090, 10'h07A, 10'h066, \
  10'h056, 10'h048}
// ******************************
// timing
// ******************************
`define SOFA_CLK_NS 20
`define SOFA_STRAP_IDLE_NS 1000000
`endif

// ---- logic/sofa_pkg.sv ----
/*
  types shared by the sensor offset, alert and addressing core.
  assumes sofa_params.svh is compiled with it.
*/
package sofa_pkg;
  // values kept in configuration storage
  typedef struct packed {
    logic combined;
    logic [7:0] short_addr;
    logic [15:0] offset;
  } sofa_nv_type;
  // strap and pin address sequencer
  typedef enum logic [2:0] {
    SOFA_IDLE, SOFA_WAIT_QUIET, SOFA_SAMPLE_STRAP, SOFA_SAMPLE_PINS, SOFA_UPDATE
  } sofa_seq_type;
endpackage

// ---- tb/sofa_core_props.sv ----
/*
  port checker for the sofa core: commit strobe, alert pin, unique address.
  assumes it is bound onto sofa_core and sees only that module's ports.
*/
`include "sofa_params.svh"
`timescale 1ns/1ns
`default_nettype none
module sofa_core_chk
  import sofa_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [47:0] SERIAL = 48'h0123_4567_89AB
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_nv_wr,
  input wire logic i_supply_powered,
  input wire logic o_threshold_flag_pin_oe_n,
  input wire logic i_uid_rewind,
  input wire logic i_uid_next,
  input wire logic o_uid_bit
);
  // one clock domain, so clocking and disable are given once
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ******************************
  // sequences
  // ******************************
  // a commit write that selects at least one field
  sequence s_commit;
    i_wr && i_addr == `SOFA_REG_COMMIT && |i_wdata[2:0];
  endsequence
  // rewind followed by the first advance of the shift index
  sequence s_first_step;
    i_uid_rewind ##1 (i_uid_next && !i_uid_rewind);
  endsequence
  // ******************************
  // assertions
  // ******************************
  a_commit_pulse: assert property (s_commit |=> o_nv_wr)
    else $error("commit write gave no storage strobe");
  a_nv_one_shot: assert property (
    o_nv_wr && !(i_wr && i_addr == `SOFA_REG_COMMIT && |i_wdata[2:0]) |=> !o_nv_wr)
    else $error("storage strobe longer than one cycle");
  a_nv_cause: assert property (o_nv_wr |-> $past(i_wr && i_addr == `SOFA_REG_COMMIT))
    else $error("storage strobe without commit write");
  a_alert_unpowered: assert property (!i_supply_powered [*4] |=> o_threshold_flag_pin_oe_n)
    else $error("alert pin driven without supply");
  a_uid_first: assert property (i_uid_rewind |=> o_uid_bit == FAMILY_CODE[0])
    else $error("first shifted bit is not family bit 0");
  a_uid_second: assert property (s_first_step |=> o_uid_bit == FAMILY_CODE[1])
    else $error("second shifted bit is not family bit 1");
  a_uid_low_word: assert property (
    i_rd && i_addr == `SOFA_REG_UID0 |=> o_rdata == {SERIAL[7:0], FAMILY_CODE})
    else $error("low address word not family and serial");
  a_uid_top_byte: assert property (
    i_rd && i_addr == `SOFA_REG_UID3 |=> o_rdata[7:0] == SERIAL[47:40])
    else $error("serial top byte changed");
endmodule
bind sofa_core sofa_core_chk #(.FAMILY_CODE(FAMILY_CODE), .SERIAL(SERIAL)) i_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_nv_wr(o_nv_wr),
  .i_supply_powered(i_supply_powered),
  .o_threshold_flag_pin_oe_n(o_threshold_flag_pin_oe_n),
  .i_uid_rewind(i_uid_rewind), .i_uid_next(i_uid_next), .o_uid_bit(o_uid_bit));
`default_nettype wire

// ---- tb/sofa_nv_model.sv ----
/*
  configuration storage model facing the sofa core.
  assumes one write strobe per commit, on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sofa_nv_model
  import sofa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_preset_en,
  input wire sofa_nv_type i_preset,
  input wire logic i_nv_wr,
  input wire sofa_nv_type i_nv_data,
  output sofa_nv_type o_nv_data
);
  // ******************************
  // storage cell
  // ******************************
  // no reset here: content must survive core resets like real storage
  // keeps committed fields
  always_ff @(posedge i_clk) begin
    if (i_preset_en) begin
      o_nv_data <= i_preset;
    end else if (i_nv_wr) begin
      o_nv_data <= i_nv_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sofa_core_test.sv ----
/*
  self-checking bench for the sofa core.
  assumes the core, its package and the storage model are compiled first.
*/
`include "sofa_params.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module sofa_core_test;
  import sofa_pkg::*;
  localparam logic [7:0] FAM = 8'h3C; // arbitrary value
  localparam logic [47:0] SER = 48'h1122_3344_5566; // arbitrary value
  localparam sofa_nv_type PRE = {1'h0, 8'hA5, 16'h0100};
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] i_raw = 16'h0000;
  logic i_wr = 1'h0, i_rd = 1'h0, i_conv = 1'h0, i_shutdown = 1'h1, i_supply = 1'h1;
  logic i_rewind = 1'h0, i_next = 1'h0, i_cmp = 1'h0, preset_en = 1'h1;
  logic i_bus = 1'h1;
  logic [9:0] i_strap = 10'h000;
  logic [3:0] i_pins = 4'h0;
  logic [15:0] o_rdata;
  sofa_nv_type nv_st, nv_out;
  logic nv_wr, flag_oe_n, flag_pin, uid_bit, uid_match;
  logic [3:0] gp_out, gp_oe_n;
  int n_mismatch = 0;
  int n_checks = 0;
  // ******************************
  // clock, design and storage
  // ******************************
  always #10 i_clk = ~i_clk;
  sofa_core #(.FAMILY_CODE(FAM), .SERIAL(SER), .STRAP_IDLE_CYCLES(4)) i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_done(i_conv),
    .i_raw_temp(i_raw), .i_shutdown(i_shutdown), .i_nv_data(nv_st),
    .o_nv_data(nv_out), .o_nv_wr(nv_wr), .i_supply_powered(i_supply),
    .i_bus_data_line(i_bus), .i_strap_level(i_strap), .i_general_purpose_pins(i_pins),
    .o_general_purpose_pins(gp_out), .o_general_purpose_pins_oe_n(gp_oe_n),
    .o_threshold_flag_pin(flag_pin), .o_threshold_flag_pin_oe_n(flag_oe_n),
    .i_uid_rewind(i_rewind), .i_uid_next(i_next), .i_uid_cmp_bit(i_cmp),
    .o_uid_bit(uid_bit), .o_uid_match(uid_match));
  sofa_nv_model i_nv (.i_clk(i_clk), .i_preset_en(preset_en), .i_preset(PRE),
    .i_nv_wr(nv_wr), .i_nv_data(nv_out), .o_nv_data(nv_st));
  // ******************************
  // bus and stimulus tasks
  // ******************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    `CHK(nm, e, o_rdata)
    // hand back on an edge so callers drive the next inputs there
    @(posedge i_clk);
  endtask
  task automatic conv(input logic [15:0] raw);
    @(posedge i_clk);
    i_conv <= 1'h1;
    i_raw <= raw;
    @(posedge i_clk);
    i_conv <= 1'h0;
  endtask
  // host side: park the selector at 00b first, then pick the mode and idle
  task automatic sel(input logic [15:0] m);
    wr(`SOFA_REG_CFG2, 16'h0000);
    wr(`SOFA_REG_CFG2, m);
    repeat (20) @(posedge i_clk);
  endtask
  task automatic do_reset();
    i_reset_n <= 1'h0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'h1;
    repeat (2) @(posedge i_clk);
  endtask
  // reflected form of polynomial 31h, zero seed, lsb first
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      fb = c[0] ^ d[i];
      c = c >> 1;
      if (fb) c = c ^ 8'h8C;
    end
    return c;
  endfunction
  // ******************************
  // scenarios
  // ******************************
  task automatic t_offset();
    rd_chk(`SOFA_REG_SHORT, 16'h00A5, "stored short");
    rd_chk(`SOFA_REG_OFFSET, 16'h0100, "stored offset");
    conv(16'h0C80);
    rd_chk(`SOFA_REG_RESULT, 16'h0D80, "result");
    conv(16'hFF00);
    rd_chk(`SOFA_REG_RESULT, 16'h0000, "signed result");
  endtask
  task automatic t_alert();
    logic [15:0] raw [4] = '{16'hFF80, 16'hFF7F, 16'h0080, 16'h0081};
    logic [15:0] st [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0002};
    wr(`SOFA_REG_OFFSET, 16'h0000);
    wr(`SOFA_REG_ALERT_LO, 16'hFF80);
    wr(`SOFA_REG_ALERT_HI, 16'h0080);
    wr(`SOFA_REG_IO_CFG, 16'h0010);
    for (int i = 0; i < 4; i++) begin
      conv(raw[i]);
      rd_chk(`SOFA_REG_STATUS, st[i], "status");
    end
    conv(16'h0100);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("alert pin", 2'h0, {flag_pin, flag_oe_n})
    rd_chk(`SOFA_REG_STATUS, 16'h0002, "latched");
    rd_chk(`SOFA_REG_STATUS, 16'h0000, "read clear");
    wr(`SOFA_REG_CFG1, 16'h0001);
    conv(16'hFF00);
    rd_chk(`SOFA_REG_STATUS, 16'h0001, "comparator");
    rd_chk(`SOFA_REG_STATUS, 16'h0001, "comparator kept");
    i_supply <= 1'h0;
    repeat (6) @(posedge i_clk);
    #1;
    `CHK("alert pin", 1'h1, flag_oe_n)
    @(posedge i_clk);
    i_supply <= 1'h1;
    wr(`SOFA_REG_CFG1, 16'h0000);
  endtask
  task automatic t_uid();
    logic [63:0] u;
    u = {crc8({SER, FAM}), SER, FAM};
    for (int w = 0; w < 4; w++)
      rd_chk(`SOFA_REG_UID0 + 8'(w), u[16*w +: 16], "uid word");
    wr(`SOFA_REG_UID0, 16'hFFFF);
    rd_chk(`SOFA_REG_UID0, u[15:0], "uid fixed");
    @(posedge i_clk);
    i_rewind <= 1'h1;
    @(posedge i_clk);
    i_rewind <= 1'h0;
    i_next <= 1'h1;
    i_cmp <= u[0];
    for (int i = 0; i < 64; i++) begin
      #1;
      `CHK("uid bit", u[i], uid_bit)
      @(posedge i_clk);
      if (i == 63) i_next <= 1'h0;
      else i_cmp <= u[i + 1];
    end
    #1;
    `CHK("uid match", 1'h1, uid_match)
    @(posedge i_clk);
    i_rewind <= 1'h1;
    @(posedge i_clk);
    i_rewind <= 1'h0;
    i_next <= 1'h1;
    i_cmp <= ~u[0];
    @(posedge i_clk);
    i_next <= 1'h0;
    #1;
    `CHK("uid mismatch", 1'h0, uid_match)
  endtask
  task automatic t_short();
    logic [9:0] lv [4] = '{10'h048, 10'h049, 10'h200, 10'h201};
    logic [3:0] cd [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
    wr(`SOFA_REG_SHORT, 16'h00C3);
    rd_chk(`SOFA_REG_SHORT, 16'h00C3, "host short");
    i_pins <= 4'hA;
    wr(`SOFA_REG_IO_CFG, 16'h0012);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("io drive", 8'h0D, {gp_out, gp_oe_n})
    rd_chk(`SOFA_REG_IO_READ, 16'h000A, "io read");
    sel(16'h0001);
    rd_chk(`SOFA_REG_SHORT, 16'h00C8, "pin short");
    wr(`SOFA_REG_SHORT, 16'h0055);
    rd_chk(`SOFA_REG_SHORT, 16'h00C8, "short locked");
    for (int i = 0; i < 4; i++) begin
      i_strap <= lv[i];
      sel(16'h0002);
      rd_chk(`SOFA_REG_SHORT, {8'h00, 4'hC, cd[i]}, "strap short");
    end
    // decode must wait for a quiet bus and for shutdown
    i_bus <= 1'h0;
    i_strap <= 10'h049;
    sel(16'h0002);
    rd_chk(`SOFA_REG_SHORT, 16'h00CF, "busy bus");
    i_bus <= 1'h1;
    i_shutdown <= 1'h0;
    repeat (20) @(posedge i_clk);
    rd_chk(`SOFA_REG_SHORT, 16'h00CF, "awake");
    i_shutdown <= 1'h1;
    repeat (20) @(posedge i_clk);
    rd_chk(`SOFA_REG_SHORT, 16'h00C1, "quiet decode");
    wr(`SOFA_REG_IO_CFG, 16'h0010);
    i_pins <= 4'h6;
    i_strap <= 10'h049;
    sel(16'h0003);
    rd_chk(`SOFA_REG_SHORT, 16'h00E1, "combined short");
    wr(`SOFA_REG_OFFSET, 16'h0040);
    wr(`SOFA_REG_COMMIT, 16'h0007);
    repeat (3) @(posedge i_clk);
    `CHK("stored", {1'h1, 8'hE1, 16'h0040}, nv_st)
    i_pins <= 4'h5;
    i_strap <= 10'h201;
    do_reset();
    repeat (20) @(posedge i_clk);
    rd_chk(`SOFA_REG_SHORT, 16'h00DF, "power up short");
    rd_chk(`SOFA_REG_OFFSET, 16'h0040, "power up offset");
    wr(`SOFA_REG_OFFSET, 16'h0020);
    wr(`SOFA_REG_COMMIT, 16'h0001);
    repeat (3) @(posedge i_clk);
    `CHK("offset only", {1'h1, 8'hE1, 16'h0020}, nv_st)
  endtask
  // ******************************
  // sequencing and verdict
  // ******************************
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    preset_en <= 1'h0;
    t_offset();
    t_alert();
    t_uid();
    t_short();
    report_and_stop();
  end
  // the whole run needs about 500 cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
